// ===== rtl/spx_exec.sv
// Purpose: Executes stack-relative move, push-literal and subtract-literal-from-pointer
// Assumes: Instruction word and memory read data are synchronous to clk
// Notes:   Instruction taken in phase Q1; memory access presented in phase Q4
`timescale 1ns/1ps

// Overview of operation
// - Stack-relative move takes two cycles: read source, then write destination.
// - Push-literal stores the 8-bit literal at stack pointer two; flags untouched.
// - After the push store, stack pointer two drops by one; single cycle.
// - Subtract 6-bit literal from selected pointer 0..2; one cycle, opcode decoded.
// - Move addresses are stack pointer two plus separate 7-bit unsigned offsets.
// - A move source hitting an indirect register reads as zero.
// - A move destination hitting an indirect register suppresses the write.
module spx_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [spx_pkg::INSTR_W-1:0] instr_word,
    output logic instr_ready,
    output logic busy,
    // Data memory
    output spx_pkg::spx_mem_t mem_req,
    input wire logic [spx_pkg::DATA_W-1:0] mem_rdata,
    input wire logic addr_indirect,
    // Pointer registers
    input wire spx_pkg::spx_ptr_load_t ptr_load,
    output logic [spx_pkg::NUM_PTR-1:0][spx_pkg::ADDR_W-1:0] ptr_out
);
    import spx_pkg::*;

    // ****************************************
    // State
    // ****************************************
    spx_phase_t phase_reg, phase_next;
    spx_state_t st_reg, st_next;
    spx_op_t op_reg, op_next;
    logic [INSTR_W-1:0] ir_reg, ir_next;
    logic [DATA_W-1:0] src_data_reg, src_data_next;
    spx_mem_t mem_reg, mem_next;
    logic [NUM_PTR-1:0][ADDR_W-1:0] ptr_reg, ptr_next;

    logic [ADDR_W-1:0] offset_ext;
    logic [ADDR_W-1:0] sub_lit_ext;
    logic [1:0] sel;

    assign offset_ext = {{(ADDR_W-OFFSET_W){1'b0}}, ir_reg[OFFSET_LSB +: OFFSET_W]};
    assign sub_lit_ext = {{(ADDR_W-SUB_LIT_W){1'b0}}, ir_reg[SUB_LIT_W-1:0]};
    assign sel = ir_reg[SEL_LSB +: 2];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        phase_next = phase_reg;
        st_next = st_reg;
        op_next = op_reg;
        ir_next = ir_reg;
        src_data_next = src_data_reg;
        mem_next = mem_reg;
        ptr_next = ptr_reg;
        if (ptr_load.en && ptr_load.sel != SEL_RETURN) begin
            ptr_next[ptr_load.sel] = ptr_load.value;
        end
        case (phase_reg)
            PH_Q1: begin
                phase_next = PH_Q2;
                op_next = OP_NONE;
                if (instr_valid) begin
                    ir_next = instr_word;
                    if (st_reg == ST_MOVE_WAIT) begin
                        st_next = ST_IDLE;
                        if (instr_word[15:12] == OPC_MOVE_DST) begin
                            op_next = OP_MOVE_DST;
                        end
                    end else if (instr_word[15:7] == OPC_MOVE_SRC) begin
                        op_next = OP_MOVE_SRC;
                        st_next = ST_MOVE_WAIT;
                    end else if (instr_word[15:8] == OPC_PUSH) begin
                        op_next = OP_PUSH;
                    end else if (instr_word[15:8] == OPC_SUB && instr_word[7:6] != SEL_RETURN) begin
                        op_next = OP_SUB;
                    end
                end
            end
            PH_Q2: begin
                phase_next = PH_Q3;
            end
            PH_Q3: begin
                phase_next = PH_Q4;
                case (op_reg)
                    OP_MOVE_SRC: begin
                        mem_next.addr = ptr_reg[STACK_PTR_IDX] + offset_ext;
                        mem_next.rd = 1'b1;
                    end
                    OP_MOVE_DST: begin
                        mem_next.addr = ptr_reg[STACK_PTR_IDX] + offset_ext;
                        mem_next.wr = 1'b1;
                        mem_next.wdata = src_data_reg;
                    end
                    OP_PUSH: begin
                        mem_next.addr = ptr_reg[STACK_PTR_IDX];
                        mem_next.wr = 1'b1;
                        mem_next.wdata = ir_reg[LIT_W-1:0];
                    end
                    default: begin
                        mem_next = mem_reg;
                    end
                endcase
            end
            PH_Q4: begin
                phase_next = PH_Q1;
                mem_next.rd = 1'b0;
                mem_next.wr = 1'b0;
                case (op_reg)
                    OP_MOVE_SRC: begin
                        src_data_next = addr_indirect ? DATA_ZERO : mem_rdata;
                    end
                    OP_PUSH: begin
                        ptr_next[STACK_PTR_IDX] = ptr_reg[STACK_PTR_IDX] - PTR_DEC;
                    end
                    OP_SUB: begin
                        ptr_next[sel] = ptr_reg[sel] - sub_lit_ext;
                    end
                    default: begin
                        src_data_next = src_data_reg;
                    end
                endcase
            end
            default: begin
                phase_next = PH_Q1;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase_reg <= PH_Q1;
            st_reg <= ST_IDLE;
            op_reg <= OP_NONE;
            ir_reg <= INSTR_RST;
            src_data_reg <= DATA_ZERO;
            mem_reg <= MEM_IDLE;
            ptr_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            st_reg <= st_next;
            op_reg <= op_next;
            ir_reg <= ir_next;
            src_data_reg <= src_data_next;
            mem_reg <= mem_next;
            ptr_reg <= ptr_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        mem_req = mem_reg;
        mem_req.wr = mem_reg.wr && !(op_reg == OP_MOVE_DST && addr_indirect);
    end
    assign instr_ready = (phase_reg == PH_Q1);
    assign busy = (st_reg == ST_MOVE_WAIT);
    assign ptr_out = ptr_reg;

    // ****************************************
    // Assertions
    // ****************************************
    logic [ADDR_W-1:0] exp_move_addr, exp_sub;
    logic exp_sub_load;
    assign exp_move_addr = ptr_reg[STACK_PTR_IDX] + offset_ext;
    assign exp_sub = ptr_reg[sel] - sub_lit_ext;
    assign exp_sub_load = ptr_load.en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_move_src_read: assert property ((op_reg == OP_MOVE_SRC && phase_reg == PH_Q4) |->
        mem_req.rd && !mem_req.wr && mem_req.addr == exp_move_addr) else $error("move source read wrong");
    a_move_wait_busy: assert property ((op_reg == OP_MOVE_SRC && phase_reg == PH_Q4) |=>
        busy && instr_ready) else $error("move second cycle not awaited");
    a_move_dst_write: assert property ((op_reg == OP_MOVE_DST && phase_reg == PH_Q4 && !addr_indirect) |->
        mem_req.wr && mem_req.wdata == src_data_reg && mem_req.addr == exp_move_addr)
        else $error("move destination write wrong");
    a_src_indirect_zero: assert property ((op_reg == OP_MOVE_SRC && phase_reg == PH_Q4 && addr_indirect) |=>
        src_data_reg == DATA_ZERO) else $error("indirect source not zero");
    a_dst_indirect_nop: assert property ((op_reg == OP_MOVE_DST && addr_indirect) |->
        !mem_req.wr) else $error("indirect destination written");
    a_push_store: assert property ((op_reg == OP_PUSH && phase_reg == PH_Q4) |->
        mem_req.wr && mem_req.addr == ptr_reg[STACK_PTR_IDX] && mem_req.wdata == ir_reg[LIT_W-1:0])
        else $error("push store wrong");
    a_push_decrement: assert property ((op_reg == OP_PUSH && phase_reg == PH_Q4 && !ptr_load.en) |=>
        ptr_reg[STACK_PTR_IDX] == $past(ptr_reg[STACK_PTR_IDX]) - PTR_DEC) else $error("push decrement wrong");
    a_push_wrap: assert property ((op_reg == OP_PUSH && phase_reg == PH_Q4 && ptr_reg[STACK_PTR_IDX] == PTR_RST) |=>
        ptr_reg[STACK_PTR_IDX] == 12'hfff) else $error("pointer did not wrap");
    a_sub_result: assert property ((op_reg == OP_SUB && phase_reg == PH_Q4 && !exp_sub_load) |=>
        ptr_reg[$past(sel)] == $past(exp_sub) && mem_req.rd == 1'b0) else $error("subtract result wrong");
endmodule

// ===== rtl/spx_pkg.sv
// Purpose: Shared constants and types for the pointer-stack instruction unit
// Assumes: 12-bit data address space, 16-bit instruction words
// Notes:   Each instruction cycle is four clock phases

// ****************************************
// Package
// ****************************************
package spx_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int NUM_PTR = 3;
    localparam int STACK_PTR_IDX = 2;
    localparam int MOVE_CYCLES = 2;

    // Opcode patterns and field positions
    localparam logic [8:0] OPC_MOVE_SRC = 9'h1d7;
    localparam logic [3:0] OPC_MOVE_DST = 4'hf;
    localparam logic [7:0] OPC_PUSH = 8'hfa;
    localparam logic [7:0] OPC_SUB = 8'he9;
    localparam logic [1:0] SEL_RETURN = 2'h3;
    localparam int OFFSET_LSB = 0;
    localparam int OFFSET_W = 7;
    localparam int LIT_W = 8;
    localparam int SUB_LIT_W = 6;
    localparam int SEL_LSB = 6;

    // Reset values and pointer decrement step
    localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] PTR_DEC = 12'h001;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} spx_phase_t;
    typedef enum logic {ST_IDLE, ST_MOVE_WAIT} spx_state_t;
    typedef enum logic [2:0] {OP_NONE, OP_MOVE_SRC, OP_MOVE_DST, OP_PUSH, OP_SUB} spx_op_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } spx_mem_t;

    typedef struct packed {
        logic en;
        logic [1:0] sel;
        logic [ADDR_W-1:0] value;
    } spx_ptr_load_t;

    localparam spx_mem_t MEM_IDLE = '{rd: 1'b0, wr: 1'b0, addr: PTR_RST, wdata: DATA_ZERO};
endpackage

// ===== sim/spx_exec_bench.sv
// Purpose: Self-checking bench for the pointer-stack instruction unit
// Assumes: Memory answers at once; indirect-register decode modelled here
// Notes:   Expected memory strobes are queued and checked by a monitor
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

// ****************************************
// Bench
// ****************************************
module spx_exec_bench;
    import spx_pkg::*;
    logic clk = 0, rstn = 0, instr_valid = 0, instr_ready, busy, addr_indirect, ind_on = 0;
    logic [INSTR_W-1:0] instr_word = INSTR_RST;
    logic [DATA_W-1:0] mem_rdata = DATA_ZERO;
    logic [ADDR_W-1:0] ind_addr = PTR_RST, v, pe;
    logic [5:0] k;
    logic [31:0] rnd = 32'h8b8c26ae;
    spx_mem_t mem_req, em;
    spx_ptr_load_t ptr_load = '0;
    logic [NUM_PTR-1:0][ADDR_W-1:0] ptr_out;
    int bad_count = 0, compares = 0;
    spx_mem_t exp_q[$];

    spx_exec i_dut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .busy(busy), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .addr_indirect(addr_indirect), .ptr_load(ptr_load), .ptr_out(ptr_out));

    // Indirect-register decode of the surrounding system
    assign addr_indirect = ind_on & (mem_req.addr == ind_addr);

    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Monitor: each strobe takes the oldest expected access
    always @(negedge clk) begin
        if (rstn && (mem_req.rd === 1'b1 || mem_req.wr === 1'b1)) begin
            em = (exp_q.size() == 0) ? MEM_IDLE : exp_q.pop_front();
            `CHK({mem_req.rd, mem_req.wr, mem_req.addr, mem_req.wr ? mem_req.wdata : DATA_ZERO}, em)
        end
    end

    task automatic wrap_up();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic issue(input logic [INSTR_W-1:0] w);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if (instr_ready === 1'b1) begin
                @(posedge clk);
                return;
            end
        end
        bad_count++;
        wrap_up();
    endtask

    task automatic finish_op();
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic setp(input logic [1:0] s, input logic [ADDR_W-1:0] val);
        @(posedge clk);
        ptr_load <= '{en: 1'b1, sel: s, value: val};
        @(posedge clk);
        ptr_load.en <= 1'b0;
    endtask

    task automatic mv(input logic [ADDR_W-1:0] p, input logic [6:0] zs, input logic [6:0] zd,
                      input logic [7:0] d, input int im);
        logic [ADDR_W-1:0] sa, da;
        sa = p + 12'(zs);
        da = p + 12'(zd);
        setp(2'h2, p);
        mem_rdata <= d;
        ind_on <= (im == 1 || im == 2);
        ind_addr <= (im == 1) ? sa : da;
        exp_q.push_back('{rd: 1'b1, wr: 1'b0, addr: sa, wdata: DATA_ZERO});
        if (im < 2) exp_q.push_back('{rd: 1'b0, wr: 1'b1, addr: da, wdata: (im == 1) ? DATA_ZERO : d});
        issue({OPC_MOVE_SRC, zs});
        @(negedge clk);
        `CHK(busy, 1'b1)
        issue((im == 3) ? {OPC_SUB, 2'h2, 6'h01} : {OPC_MOVE_DST, 5'h00, zd});
        finish_op();
        `CHK(ptr_out[2], p)
        `CHK(exp_q.size(), 0)
        `CHK(busy, 1'b0)
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK(instr_ready, 1'b1)
        `CHK(ptr_out[2], PTR_RST)
        setp(2'h2, 12'h080);
        exp_q.push_back('{rd: 1'b0, wr: 1'b1, addr: 12'h080, wdata: 8'h08});
        issue(16'hfa08);
        finish_op();
        `CHK(ptr_out[2], 12'h07f)
        setp(2'h2, 12'h001);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            exp_q.push_back('{rd: 1'b0, wr: 1'b1, addr: 12'h001 - 12'(i), wdata: rnd[7:0]});
            issue({OPC_PUSH, rnd[7:0]});
        end
        finish_op();
        `CHK(ptr_out[2], 12'hffe)
        $display("test push done");
        for (int s = 0; s < 4; s++) begin
            rnd = lfsr(rnd);
            v = (s == 1) ? 12'h020 : rnd[27:16];
            k = (s == 1) ? 6'h3f : rnd[5:0];
            if (s < 3) begin
                setp(2'(s), v);
                pe = v - 12'(k);
            end
            issue({OPC_SUB, 2'(s), k});
            finish_op();
            `CHK(ptr_out[(s == 3) ? 2 : s], pe)
        end
        `CHK(exp_q.size(), 0)
        $display("test subtract done");
        mv(12'h080, 7'h05, 7'h06, 8'h33, 0);
        mv(12'hff0, 7'h7f, 7'h00, rnd[15:8], 1);
        mv(12'h100, 7'h00, 7'h7f, 8'h5a, 2);
        mv(12'h200, 7'h01, 7'h02, 8'ha5, 3);
        $display("test move done");
        wrap_up();
    end
endmodule
